// ---- src/osa_defines.svh ----
// Register offsets, reset values and field positions of the output assignment selector
`ifndef OSA_DEFINES_SVH
`define OSA_DEFINES_SVH

`define OSA_NUM_OUT 8
`define OSA_CODE_W 8
`define OSA_ASSIGN_BASE 8'h00
`define OSA_OUTSTATE_OFS 8'h20
`define OSA_IRQSTAT_OFS 8'h24
`define OSA_IRQMASK_OFS 8'h28
`define OSA_SRCMON_OFS 8'h2C
`define OSA_ASSIGN_RST 8'h00
`define OSA_IRQMASK_RST 3'h0
`define OSA_IRQ_REJECT_BIT 0
`define OSA_IRQ_CHANGE_BIT 1
`define OSA_IRQ_ALARM_BIT 2
`define OSA_IRQ_W 3
`define OSA_IDX_OUTSTATE 4'h8
`define OSA_IDX_IRQSTAT 4'h9
`define OSA_IDX_IRQMASK 4'hA
`define OSA_IDX_SRCMON 4'hB
`define OSA_IDX_NONE 4'hF

`endif

// ---- src/osa_pkg.sv ----
// Types of the output assignment selector
`default_nettype none
package osa_pkg;

  typedef logic [7:0] osa_code_t;

  typedef enum logic [7:0] {
    OSA_UNUSED = 8'h00,
    OSA_FWD_CONT = 8'h38,
    OSA_REV_CONT = 8'h39,
    OSA_DSEL_FIRST = 8'h40,
    OSA_DSEL_LAST = 8'h47,
    OSA_TEACH = 8'h4B,
    OSA_MON_REQ0 = 8'h4C,
    OSA_MON_REQ1 = 8'h4D,
    OSA_MON_SHIFT = 8'h4E,
    OSA_PULSE_EN = 8'h4F,
    OSA_GEN_FIRST = 8'h50,
    OSA_GEN_LAST = 8'h5F,
    OSA_CONST_OFF = 8'h80,
    OSA_ALARM_HI = 8'h81,
    OSA_ALARM_LO = 8'h82,
    OSA_POWERED = 8'h83,
    OSA_READY = 8'h84,
    OSA_MOVING = 8'h86,
    OSA_NOTICE = 8'h87,
    OSA_BUSY = 8'h88,
    OSA_TRQ_OFF_PEND = 8'h89,
    OSA_POS_DONE = 8'h8A,
    OSA_ZERO_SPEED = 8'h8B,
    OSA_TRQ_LIMIT = 8'h8C,
    OSA_SPEED_TGT = 8'h8D,
    OSA_EXCITED = 8'h8E
  } osa_code_e_t;

  typedef struct packed {
    logic fwd;
    logic rev;
    logic [7:0] dsel;
    logic teach;
    logic monReq0;
    logic monReq1;
    logic monShift;
    logic pulseEn;
    logic [15:0] gen;
    logic alarm;
    logic powered;
    logic ready;
    logic moving;
    logic notice;
    logic busy;
    logic trqOffPend;
    logic posDone;
    logic zeroSpd;
    logic trqLim;
    logic spdTgt;
    logic excited;
  } osa_src_t;

endpackage
`default_nettype wire

// ---- src/osa_output_select.sv ----
// Output assignment selector with AHB-Lite register slave and interrupt
//
// Behaviour
// - Code 128 holds output permanently off
// - Code 129 outputs alarm, normally open
// - Code 130 outputs alarm, normally closed
// - Code 131 outputs control supply powered
// - Code 132 outputs driver ready to operate
// - Code 134 outputs motor in motion
// - Code 135 outputs information notice status
// - Code 136 outputs internal processing busy
// - Code 137: torque-off until motor re-excited
// - Code 138 outputs positioning completed
// - Code 139 outputs feedback speed zero
// - Code 140 outputs torque at limit
// - Code 141 outputs speed reached target
// - Code 142 outputs windings excited
// - Codes 80 to 95 echo general inputs
// - Code 0 leaves the output unused
`include "osa_defines.svh"
`default_nettype none
module osa_output_select (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic fwdContinuousEcho,
  input wire logic revContinuousEcho,
  input wire logic [7:0] dataSelEcho,
  input wire logic teachRequestEcho,
  input wire logic posMonitorReq0Echo,
  input wire logic posMonitorReq1Echo,
  input wire logic posMonitorShiftEcho,
  input wire logic pulseRequestEnEcho,
  input wire logic [15:0] generalInEcho,
  input wire logic alarmPresent,
  input wire logic logicPowered,
  input wire logic driverReady,
  input wire logic motorMoving,
  input wire logic noticeFlag,
  input wire logic internalBusy,
  input wire logic safeTorqueOffInA,
  input wire logic safeTorqueOffInB,
  input wire logic positioningDone,
  input wire logic zeroSpeed,
  input wire logic torqueAtLimit,
  input wire logic speedAtTarget,
  input wire logic windingsExcited,
  output logic [`OSA_NUM_OUT-1:0] outPos,
  output logic irq
);

  osa_pkg::osa_code_t assign_reg [`OSA_NUM_OUT];
  logic [`OSA_NUM_OUT-1:0] outPos_next;
  logic [`OSA_IRQ_W-1:0] irqStat_reg;
  logic [`OSA_IRQ_W-1:0] irqMask_reg;
  logic trqOffPend_reg;
  logic alarmPrev_reg;
  logic wrPend_reg;
  logic [3:0] wrIdx_reg;
  logic [31:0] rdData_next;
  logic addrPhase;
  logic [3:0] addrIdx;
  logic wrReject;
  logic wrAccept;
  osa_pkg::osa_src_t src;

  // Code table; anything not listed is an illegal selection
  function automatic logic codeValid(input osa_pkg::osa_code_t code);
    logic ok;
    ok = 1'b0;
    case (code) inside
      osa_pkg::OSA_UNUSED, osa_pkg::OSA_FWD_CONT, osa_pkg::OSA_REV_CONT: ok = 1'b1;
      [osa_pkg::OSA_DSEL_FIRST:osa_pkg::OSA_DSEL_LAST]: ok = 1'b1;
      [osa_pkg::OSA_TEACH:osa_pkg::OSA_PULSE_EN]: ok = 1'b1;
      [osa_pkg::OSA_GEN_FIRST:osa_pkg::OSA_GEN_LAST]: ok = 1'b1;
      [osa_pkg::OSA_CONST_OFF:osa_pkg::OSA_READY]: ok = 1'b1;
      [osa_pkg::OSA_MOVING:osa_pkg::OSA_EXCITED]: ok = 1'b1;
      default: ok = 1'b0;
    endcase
    return ok;
  endfunction

  function automatic logic selectSrc(input osa_pkg::osa_code_t code, input osa_pkg::osa_src_t s);
    logic v;
    v = 1'b0;
    case (code) inside
      osa_pkg::OSA_FWD_CONT: v = s.fwd;
      osa_pkg::OSA_REV_CONT: v = s.rev;
      [osa_pkg::OSA_DSEL_FIRST:osa_pkg::OSA_DSEL_LAST]: v = s.dsel[code[2:0]];
      osa_pkg::OSA_TEACH: v = s.teach;
      osa_pkg::OSA_MON_REQ0: v = s.monReq0;
      osa_pkg::OSA_MON_REQ1: v = s.monReq1;
      osa_pkg::OSA_MON_SHIFT: v = s.monShift;
      osa_pkg::OSA_PULSE_EN: v = s.pulseEn;
      [osa_pkg::OSA_GEN_FIRST:osa_pkg::OSA_GEN_LAST]: v = s.gen[code[3:0]];
      osa_pkg::OSA_CONST_OFF: v = 1'b0;
      osa_pkg::OSA_ALARM_HI: v = s.alarm;
      osa_pkg::OSA_ALARM_LO: v = ~s.alarm;
      osa_pkg::OSA_POWERED: v = s.powered;
      osa_pkg::OSA_READY: v = s.ready;
      osa_pkg::OSA_MOVING: v = s.moving;
      osa_pkg::OSA_NOTICE: v = s.notice;
      osa_pkg::OSA_BUSY: v = s.busy;
      osa_pkg::OSA_TRQ_OFF_PEND: v = s.trqOffPend;
      osa_pkg::OSA_POS_DONE: v = s.posDone;
      osa_pkg::OSA_ZERO_SPEED: v = s.zeroSpd;
      osa_pkg::OSA_TRQ_LIMIT: v = s.trqLim;
      osa_pkg::OSA_SPEED_TGT: v = s.spdTgt;
      osa_pkg::OSA_EXCITED: v = s.excited;
      default: v = 1'b0;
    endcase
    return v;
  endfunction

  // Word offset to register index; upper address bits must be clear
  function automatic logic [3:0] decodeAddr(input logic [31:0] a);
    logic [3:0] idx;
    idx = `OSA_IDX_NONE;
    if (a[31:6] == 26'h0 && a[1:0] == 2'h0) begin
      if (a[7:0] < `OSA_OUTSTATE_OFS) begin
        idx = {1'b0, a[4:2]};
      end else if (a[7:0] == `OSA_OUTSTATE_OFS) begin
        idx = `OSA_IDX_OUTSTATE;
      end else if (a[7:0] == `OSA_IRQSTAT_OFS) begin
        idx = `OSA_IDX_IRQSTAT;
      end else if (a[7:0] == `OSA_IRQMASK_OFS) begin
        idx = `OSA_IDX_IRQMASK;
      end else if (a[7:0] == `OSA_SRCMON_OFS) begin
        idx = `OSA_IDX_SRCMON;
      end
    end
    return idx;
  endfunction

  always_comb begin
    src.fwd = fwdContinuousEcho;
    src.rev = revContinuousEcho;
    src.dsel = dataSelEcho;
    src.teach = teachRequestEcho;
    src.monReq0 = posMonitorReq0Echo;
    src.monReq1 = posMonitorReq1Echo;
    src.monShift = posMonitorShiftEcho;
    src.pulseEn = pulseRequestEnEcho;
    src.gen = generalInEcho;
    src.alarm = alarmPresent;
    src.powered = logicPowered;
    src.ready = driverReady;
    src.moving = motorMoving;
    src.notice = noticeFlag;
    src.busy = internalBusy;
    src.trqOffPend = trqOffPend_reg;
    src.posDone = positioningDone;
    src.zeroSpd = zeroSpeed;
    src.trqLim = torqueAtLimit;
    src.spdTgt = speedAtTarget;
    src.excited = windingsExcited;
  end

  // Only whole-word transfers are taken; others get OKAY and no effect
  assign addrPhase = hsel & htrans[1] & hready & (hsize == 3'h2);
  assign addrIdx = decodeAddr(haddr);
  assign wrAccept = wrPend_reg & ~wrIdx_reg[3] & codeValid(hwdata[7:0]);
  assign wrReject = wrPend_reg & ~wrIdx_reg[3] & ~codeValid(hwdata[7:0]);

  // Zero-wait slave: not ready during reset, ready from the first enabled cycle after it, and always OKAY
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hreadyout <= 1'b0;
      hresp <= 1'b0;
    end else if (ce) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wrPend_reg <= 1'b0;
      wrIdx_reg <= `OSA_IDX_NONE;
    end else if (ce) begin
      wrPend_reg <= addrPhase & hwrite;
      wrIdx_reg <= addrIdx;
    end
  end

  always_comb begin
    rdData_next = 32'h0;
    if (!addrIdx[3]) begin
      rdData_next[7:0] = assign_reg[addrIdx[2:0]];
    end else if (addrIdx == `OSA_IDX_OUTSTATE) begin
      rdData_next[`OSA_NUM_OUT-1:0] = outPos;
    end else if (addrIdx == `OSA_IDX_IRQSTAT) begin
      rdData_next[`OSA_IRQ_W-1:0] = irqStat_reg;
    end else if (addrIdx == `OSA_IDX_IRQMASK) begin
      rdData_next[`OSA_IRQ_W-1:0] = irqMask_reg;
    end else if (addrIdx == `OSA_IDX_SRCMON) begin
      rdData_next[1:0] = {alarmPresent, trqOffPend_reg};
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hrdata <= 32'h0;
    end else if (ce && addrPhase && !hwrite) begin
      hrdata <= rdData_next;
    end
  end

  // A refused code leaves the previous selection in force
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < `OSA_NUM_OUT; i++) begin
        assign_reg[i] <= `OSA_ASSIGN_RST;
      end
    end else if (ce && wrAccept) begin
      assign_reg[wrIdx_reg[2:0]] <= hwdata[7:0];
    end
  end

  // Pending from any torque-off input low; only re-excitation with both inputs back clears it
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      trqOffPend_reg <= 1'b0;
    end else if (ce) begin
      if (!safeTorqueOffInA || !safeTorqueOffInB) begin
        trqOffPend_reg <= 1'b1;
      end else if (windingsExcited) begin
        trqOffPend_reg <= 1'b0;
      end
    end
  end

  for (genvar g = 0; g < `OSA_NUM_OUT; g++) begin : gSel
    assign outPos_next[g] = selectSrc(assign_reg[g], src);
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      outPos <= '0;
    end else if (ce) begin
      outPos <= outPos_next;
    end
  end

  // Hardware set wins over a write-one clear in the same cycle
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irqStat_reg <= '0;
      irqMask_reg <= `OSA_IRQMASK_RST;
      alarmPrev_reg <= 1'b0;
    end else if (ce) begin
      alarmPrev_reg <= alarmPresent;
      if (wrPend_reg && wrIdx_reg == `OSA_IDX_IRQMASK) begin
        irqMask_reg <= hwdata[`OSA_IRQ_W-1:0];
      end
      irqStat_reg <= (irqStat_reg & ~((wrPend_reg && wrIdx_reg == `OSA_IDX_IRQSTAT) ?
        hwdata[`OSA_IRQ_W-1:0] : 3'h0)) |
        {alarmPresent & ~alarmPrev_reg, outPos_next != outPos, wrReject};
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irq <= 1'b0;
    end else if (ce) begin
      irq <= |(irqStat_reg & irqMask_reg);
    end
  end

  logic gen0Sel;
  assign gen0Sel = generalInEcho[assign_reg[0][3:0]];
  logic irqPend;
  assign irqPend = |(irqStat_reg & irqMask_reg);

  AST_CONST_OFF: assert property (@(posedge clk) disable iff (rst)
    ce && assign_reg[0] == osa_pkg::OSA_CONST_OFF |=> !outPos[0])
    else $error("Code 128 output not held off");

  AST_ALARM_HI: assert property (@(posedge clk) disable iff (rst)
    ce && assign_reg[1] == osa_pkg::OSA_ALARM_HI |=> outPos[1] == $past(alarmPresent))
    else $error("Normally open alarm output wrong");

  AST_ALARM_LO: assert property (@(posedge clk) disable iff (rst)
    ce && assign_reg[2] == osa_pkg::OSA_ALARM_LO |=> outPos[2] == !$past(alarmPresent))
    else $error("Normally closed alarm output wrong");

  AST_MOVING: assert property (@(posedge clk) disable iff (rst)
    ce && assign_reg[5] == osa_pkg::OSA_MOVING |=> outPos[5] == $past(motorMoving))
    else $error("Motion output does not follow motion");

  AST_TRQ_OFF: assert property (@(posedge clk) disable iff (rst)
    ce && (!safeTorqueOffInA || !safeTorqueOffInB) |=> trqOffPend_reg)
    else $error("Torque-off pending not raised");

  // Only re-excitation may end the pending state, never the inputs alone
  AST_TRQ_HOLD: assert property (@(posedge clk) disable iff (rst)
    ce && trqOffPend_reg && !windingsExcited |=> trqOffPend_reg)
    else $error("Torque-off pending dropped before excitation");

  AST_TRQ_OUT: assert property (@(posedge clk) disable iff (rst)
    ce && assign_reg[0] == osa_pkg::OSA_TRQ_OFF_PEND |=> outPos[0] == $past(trqOffPend_reg))
    else $error("Torque-off output does not follow pending state");

  AST_EXCITED: assert property (@(posedge clk) disable iff (rst)
    ce && assign_reg[5] == osa_pkg::OSA_EXCITED |=> outPos[5] == $past(windingsExcited))
    else $error("Excitation output wrong");

  AST_GEN_ECHO: assert property (@(posedge clk) disable iff (rst)
    ce && assign_reg[0] inside {[osa_pkg::OSA_GEN_FIRST:osa_pkg::OSA_GEN_LAST]} |=> outPos[0] == $past(gen0Sel))
    else $error("General input echo wrong");

  AST_UNUSED: assert property (@(posedge clk) disable iff (rst)
    ce && assign_reg[4] == osa_pkg::OSA_UNUSED |=> !outPos[4])
    else $error("Unused output is driven");

  AST_REJECT: assert property (@(posedge clk) disable iff (rst)
    ce && wrPend_reg && wrIdx_reg == 4'h0 && !codeValid(hwdata[7:0])
      |=> assign_reg[0] == $past(assign_reg[0]) && irqStat_reg[`OSA_IRQ_REJECT_BIT])
    else $error("Undefined code accepted");

  AST_IRQ: assert property (@(posedge clk) disable iff (rst)
    ce |=> irq == $past(irqPend))
    else $error("Interrupt does not follow unmasked status");

  AST_POWERED: assert property (@(posedge clk) disable iff (rst)
    ce && assign_reg[3] == osa_pkg::OSA_POWERED |=> outPos[3] == $past(logicPowered))
    else $error("Powered output wrong");

  AST_READY: assert property (@(posedge clk) disable iff (rst)
    ce && assign_reg[4] == osa_pkg::OSA_READY |=> outPos[4] == $past(driverReady))
    else $error("Ready output wrong");

  AST_NOTICE: assert property (@(posedge clk) disable iff (rst)
    ce && assign_reg[6] == osa_pkg::OSA_NOTICE |=> outPos[6] == $past(noticeFlag))
    else $error("Notice output wrong");

  AST_BUSY: assert property (@(posedge clk) disable iff (rst)
    ce && assign_reg[7] == osa_pkg::OSA_BUSY |=> outPos[7] == $past(internalBusy))
    else $error("Busy output wrong");

  AST_POS_DONE: assert property (@(posedge clk) disable iff (rst)
    ce && assign_reg[1] == osa_pkg::OSA_POS_DONE |=> outPos[1] == $past(positioningDone))
    else $error("Positioning done output wrong");

  AST_ZERO_SPEED: assert property (@(posedge clk) disable iff (rst)
    ce && assign_reg[2] == osa_pkg::OSA_ZERO_SPEED |=> outPos[2] == $past(zeroSpeed))
    else $error("Zero speed output wrong");

  AST_TRQ_LIMIT: assert property (@(posedge clk) disable iff (rst)
    ce && assign_reg[3] == osa_pkg::OSA_TRQ_LIMIT |=> outPos[3] == $past(torqueAtLimit))
    else $error("Torque limit output wrong");

  AST_SPEED_TGT: assert property (@(posedge clk) disable iff (rst)
    ce && assign_reg[4] == osa_pkg::OSA_SPEED_TGT |=> outPos[4] == $past(speedAtTarget))
    else $error("Speed reached output wrong");

  AST_FWD_ECHO: assert property (@(posedge clk) disable iff (rst)
    ce && assign_reg[1] == osa_pkg::OSA_FWD_CONT |=> outPos[1] == $past(fwdContinuousEcho))
    else $error("Forward continuous echo wrong");

  COV_WRITE_OK: cover property (@(posedge clk) disable iff (rst) ce && wrAccept);
  COV_REJECT: cover property (@(posedge clk) disable iff (rst) ce && wrReject);
  COV_IRQ: cover property (@(posedge clk) disable iff (rst) irq);
  COV_TRQ_OFF_CLR: cover property (@(posedge clk) disable iff (rst) trqOffPend_reg ##1 !trqOffPend_reg);
  COV_FREEZE: cover property (@(posedge clk) disable iff (rst) !ce ##1 ce);

endmodule // osa_output_select
`default_nettype wire

// ---- test/osa_host_model.sv ----
// Host model: AHB-Lite master that reads and writes the selector's registers
`default_nettype none
module osa_host_model (
  input wire logic clk,
  output logic hsel,
  output logic [31:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
  end

  // Address phase stands until hready, then data phase stands until hready again
  task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] d, output logic [31:0] rd);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= wr;
    hsize <= 3'h2;
    @(posedge clk);
    while (!hready) @(posedge clk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge clk);
    while (!hready) @(posedge clk);
    rd = hrdata;
  endtask
endmodule // osa_host_model
`default_nettype wire

// ---- test/osa_output_select_test.sv ----
// Self-checking testbench of the output assignment selector
`default_nettype none
module osa_output_select_test;
  timeunit 1ns;
  timeprecision 1ps;

  logic clk;
  logic rst;
  logic ce;
  logic hsel;
  logic [31:0] haddr;
  logic [1:0] htrans;
  logic hwrite;
  logic [2:0] hsize;
  logic [31:0] hwdata;
  logic hreadyout;
  logic hresp;
  logic [31:0] hrdata;
  logic [43:0] src;
  logic [7:0] outPos;
  logic irq;
  logic pend;
  logic [7:0] codes[$];
  logic [7:0] asg[8];
  logic [31:0] rd;
  logic [63:0] rnd;
  logic [43:0] tmp;
  int miscompares = 0;
  int numChecks = 0;
  integer seed = 32'h538B94F8;

  // Clock enable stays high while the bus is used: the slave freezes without it
  osa_output_select dut (.clk(clk), .rst(rst), .ce(ce), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .fwdContinuousEcho(src[0]), .revContinuousEcho(src[1]), .dataSelEcho(src[9:2]),
    .teachRequestEcho(src[10]), .posMonitorReq0Echo(src[11]), .posMonitorReq1Echo(src[12]),
    .posMonitorShiftEcho(src[13]), .pulseRequestEnEcho(src[14]), .generalInEcho(src[30:15]),
    .alarmPresent(src[31]), .logicPowered(src[32]), .driverReady(src[33]), .motorMoving(src[34]),
    .noticeFlag(src[35]), .internalBusy(src[36]), .safeTorqueOffInA(src[37]), .safeTorqueOffInB(src[38]),
    .positioningDone(src[39]), .zeroSpeed(src[40]), .torqueAtLimit(src[41]), .speedAtTarget(src[42]),
    .windingsExcited(src[43]), .outPos(outPos), .irq(irq));

  osa_host_model host (.clk(clk), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    numChecks++;
    if (seen !== exp) begin
      $display("mismatch %s expected %h seen %h", name, exp, seen);
      miscompares++;
    end
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", numChecks, miscompares);
    if (miscompares == 0 && numChecks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  initial begin
    repeat (50000) @(posedge clk);
    miscompares++;
    give_verdict();
  end

  function automatic logic validCode(input int c);
    return c == 0 || c == 56 || c == 57 || (c >= 64 && c <= 71) || (c >= 75 && c <= 95) ||
      (c >= 128 && c <= 142 && c != 133);
  endfunction

  function automatic logic expOut(input logic [7:0] c, input logic [43:0] s, input logic p);
    if (c == 8'h38 || c == 8'h39) return s[c - 8'h38];
    if (c >= 8'h40 && c <= 8'h47) return s[c - 8'h3E];
    if (c >= 8'h4B && c <= 8'h5F) return s[c - 8'h41];
    if (c == 8'h83 || c == 8'h84 || (c >= 8'h8A && c <= 8'h8E)) return s[c - 8'h63];
    if (c >= 8'h86 && c <= 8'h88) return s[c - 8'h64];
    if (c == 8'h81) return s[31];
    if (c == 8'h82) return !s[31];
    if (c == 8'h89) return p;
    return 1'b0;
  endfunction

  function automatic logic [31:0] expVec();
    logic [31:0] v;
    v = 32'h0;
    for (int i = 0; i < 8; i++) v[i] = expOut(asg[i], src, pend);
    return v;
  endfunction

  task automatic regWr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] unused;
    host.xfer(1'b1, a, d, unused);
  endtask

  task automatic regRd(input logic [31:0] a, output logic [31:0] d);
    host.xfer(1'b0, a, 32'h0, d);
  endtask

  // Torque-off pending latches while either input is low, until both are high with windings excited
  task automatic step(input logic [43:0] s);
    @(posedge clk);
    src <= s;
    if (!s[37] || !s[38]) pend = 1'b1;
    else if (s[43]) pend = 1'b0;
    repeat (3) @(posedge clk);
    #1;
    check("outPos", {24'h0, outPos}, expVec());
  endtask

  initial begin
    rst = 1'b1;
    ce = 1'b1;
    src = 44'h0;
    pend = 1'b1;
    for (int c = 0; c < 256; c++) if (validCode(c)) codes.push_back(c[7:0]);
    for (int i = 0; i < 8; i++) asg[i] = 8'h00;
    repeat (16) @(posedge clk);
    check("hreadyoutReset", {31'h0, hreadyout}, 32'h0);
    rst <= 1'b0;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    for (int i = 0; i < 8; i++) begin
      regRd(4 * i, rd);
      check("assignReset", rd, 32'h0);
    end
    check("outPosReset", {24'h0, outPos}, 32'h0);
    regRd(32'h30, rd);
    check("unmapped", rd, 32'h0);
    // Every valid code at least once, with corner and random inputs under it
    for (int k = 0; k < codes.size(); k += 8) begin
      for (int i = 0; i < 8; i++) begin
        asg[i] = codes[(k + i) % codes.size()];
        regWr(4 * i, {24'h0, asg[i]});
      end
      step(44'h0);
      step({44{1'b1}});
      repeat (4) begin
        rnd = {$random(seed), $random(seed)};
        step(rnd[43:0]);
      end
      regRd(32'h20, rd);
      check("outState", rd, expVec());
      regRd(32'h2C, rd);
      check("srcMon", rd, {30'h0, src[31], pend});
      check("hresp", {31'h0, hresp}, 32'h0);
    end
    // Refused codes leave the register alone and flag the rejection
    regWr(32'h28, 32'h1);
    regRd(32'h28, rd);
    check("irqMask", rd, 32'h1);
    foreach (codes[j]) if (codes[j] == 8'h89) asg[0] = 8'h89;
    regWr(32'h0, 32'h89);
    for (int c = 0; c < 256; c += 31) begin
      if (!validCode(c)) begin
        regWr(32'h24, 32'h7);
        regWr(32'h0, c);
        regRd(32'h0, rd);
        check("refusedCode", rd, 32'h89);
        regRd(32'h24, rd);
        check("rejectFlag", {31'h0, rd[0]}, 32'h1);
        check("irqRaised", {31'h0, irq}, 32'h1);
      end
    end
    regWr(32'h24, 32'h1);
    repeat (2) @(posedge clk);
    check("irqCleared", {31'h0, irq}, 32'h0);
    // Alarm edge raises the interrupt only when unmasked
    tmp = src;
    tmp[31] = 1'b0;
    step(tmp);
    regWr(32'h28, 32'h4);
    regWr(32'h24, 32'h7);
    repeat (2) @(posedge clk);
    check("irqQuiet", {31'h0, irq}, 32'h0);
    tmp[31] = 1'b1;
    step(tmp);
    check("irqAlarm", {31'h0, irq}, 32'h1);
    regWr(32'h28, 32'h0);
    repeat (2) @(posedge clk);
    check("irqMasked", {31'h0, irq}, 32'h0);
    regRd(32'h24, rd);
    check("alarmFlag", {31'h0, rd[2]}, 32'h1);
    // Clock enable low freezes every output while the inputs move
    rd = expVec();
    ce <= 1'b0;
    src <= ~tmp;
    repeat (4) @(posedge clk);
    check("outPosFrozen", {24'h0, outPos}, rd);
    ce <= 1'b1;
    step(~tmp);
    give_verdict();
  end
endmodule // osa_output_select_test
`default_nettype wire
